//--- common/rs485_dir_pkg.sv
// Purpose: Shared constants and types for the line-direction controller
// Assumes: 25 MHz system clock, AHB-Lite register access
// Notes:   Each port has one config word and a nibble in the status word
package rs485_dir_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned MAX_LINE_BPS = 460_800;
  // Bit time at the fastest line rate, rounded down
  localparam int unsigned BIT_CYCLES   = CLK_HZ / MAX_LINE_BPS;

  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned CFG_W     = 3;
  localparam int unsigned STAT_W    = 4;

  localparam logic [7:0] OFS_PORT0_MODE = 8'h00;
  localparam logic [7:0] OFS_PORT1_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;

  // Config word fields
  localparam int unsigned POS_RTS_FOLLOW = 0;
  localparam int unsigned POS_AUTO_DIR   = 1;
  localparam int unsigned POS_NO_ECHO    = 2;

  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic no_echo_setting;
    logic auto_direction_setting;
    logic rts_follow_setting;
  } port_cfg_type;

  typedef struct packed {
    logic rx_enabled;
    logic drv_enabled;
    logic tx_busy;
    logic rts;
  } port_stat_type;

  typedef enum logic [1:0] {
    MODE_RS422 = 2'b00,
    MODE_RTS   = 2'b01,
    MODE_AUTO  = 2'b10
  } dir_mode_type;

endpackage

//--- core/port_dir_ctrl.sv
// Purpose: Driver and receiver enable control for one serial port
// Assumes: UART signals on sys_clk; line receive pin asynchronous
// Notes:   Driver enable and line data share one register stage
`timescale 1ns/1ns
module port_dir_ctrl
  import rs485_dir_pkg::*;
(
  input  wire logic          sys_clk,     // System clock
  input  wire logic          rst,         // Synchronous reset
  input  wire port_cfg_type  cfg,         // Port mode settings
  input  wire logic          rts_req,     // UART request to send
  input  wire logic          tx_busy,     // UART transmitter active
  input  wire logic          uart_txd,    // UART serial out
  input  wire logic          line_rx_i,   // Line receiver data
  output logic               line_tx_o,   // Line driver data
  output logic               line_tx_oe,  // Line driver enable
  output logic               rx_enable,   // Receiver enable
  output logic               uart_rxd,    // Serial in to UART
  output port_stat_type      stat         // Port status
);

  logic         drv_r;
  logic         txd_r;
  logic         rxen_r;
  logic         rxd_r;
  logic [2:0]   sync_r;
  logic         rx_filt_r;
  dir_mode_type mode;
  logic         grant_nxt;
  logic         rxen_nxt;

  // Auto takes precedence when both enable settings are present
  assign mode = cfg.auto_direction_setting ? MODE_AUTO :
                cfg.rts_follow_setting     ? MODE_RTS  : MODE_RS422;

  always_comb
  begin
    unique case (mode)
      MODE_AUTO:  grant_nxt = tx_busy;
      MODE_RTS:   grant_nxt = rts_req;
      MODE_RS422: grant_nxt = 1'b1;
      default:    grant_nxt = 1'b0;
    endcase
  end

  // Echo keeps receiver on; no-echo mutes it while driving in RTS or auto mode
  assign rxen_nxt = !(cfg.no_echo_setting && mode != MODE_RS422 && grant_nxt);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      drv_r     <= 1'b0;
      txd_r     <= 1'b1;
      rxen_r    <= 1'b1;
      rxd_r     <= 1'b1;
      sync_r    <= 3'h7;
      rx_filt_r <= 1'b1;
    end
    else
    begin
      drv_r  <= grant_nxt;
      txd_r  <= uart_txd;
      rxen_r <= rxen_nxt;
      sync_r <= {sync_r[1:0], line_rx_i};
      if (sync_r[2] == sync_r[1])
        rx_filt_r <= sync_r[2];
      rxd_r  <= rxen_nxt ? rx_filt_r : 1'b1;
    end
  end

  assign line_tx_o  = txd_r;
  assign line_tx_oe = drv_r;
  assign rx_enable  = rxen_r;
  assign uart_rxd   = rxd_r;
  assign stat       = '{rx_enabled: rxen_r, drv_enabled: drv_r,
                        tx_busy: tx_busy, rts: rts_req};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_auto_steady;
    $stable(cfg) && mode == MODE_AUTO;
  endsequence

  sequence s_busy_rise;
    s_auto_steady ##0 $rose(tx_busy);
  endsequence

  a_auto_drive_on: assert property (
    s_busy_rise ##1 $stable(cfg) |-> line_tx_oe)
    else $error("auto driver not enabled after busy");
  a_auto_release: assert property (
    s_auto_steady ##0 $fell(tx_busy) ##1 $stable(cfg) |-> !line_tx_oe)
    else $error("auto driver held after stop bit");
  a_auto_covers: assert property (
    s_auto_steady ##1 $stable(cfg) && $past(tx_busy) |-> line_tx_oe)
    else $error("auto driver dropped mid character");
  a_rts_follow: assert property (
    mode == MODE_RTS && $stable(cfg) ##1 $stable(cfg) |-> line_tx_oe == $past(rts_req))
    else $error("driver does not follow rts");
  a_idle_hiz: assert property (
    mode != MODE_RS422 && !grant_nxt ##1 $stable(cfg) |-> !line_tx_oe)
    else $error("driver active without grant");
  // Reset cycle excluded: driver comes up one edge after release
  a_rs422_on: assert property (
    mode == MODE_RS422 && !rst ##1 $stable(cfg) |-> line_tx_oe && rx_enable)
    else $error("rs422 port not driving");
  a_echo_rx: assert property (!cfg.no_echo_setting ##1 $stable(cfg) |-> rx_enable)
    else $error("echo port receiver muted");
  a_no_echo_mute: assert property (
    line_tx_oe && mode != MODE_RS422 && cfg.no_echo_setting && $stable(cfg)
      |-> !rx_enable && uart_rxd)
    else $error("own transmission heard in no-echo");
  a_txd_align: assert property (
    line_tx_oe |-> line_tx_o == $past(uart_txd) && BIT_CYCLES > 1)
    else $error("line data lags driver enable");

endmodule

//--- core/rs485_dir_ctrl.sv
// Purpose: Two-port RS-485 line-direction control with AHB-Lite registers
// Assumes: UART and bus on sys_clk; zero-wait-state slave, OKAY only
// Notes:   Port mode words at 0x00 and 0x04, status at 0x08
//
// Contract
// - A port drives its line only while granted, otherwise stays high impedance.
// - In RTS mode the driver enable follows the UART request-to-send output.
// - In automatic mode transmit activity alone switches the driver on and off.
// - With echo, receiver stays on so own characters come back.
// - With no-echo, receiver is off while own driver is on (in RS-422 mode the receiver stays on).
// - With no enable mode set, port runs as RS-422 with driver always on.
// - Two ports with independent mode and echo settings.
// - Direction control keeps pace with 460.8K line rates without damaging characters.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module rs485_dir_ctrl
  import rs485_dir_pkg::*;
(
  input  wire logic                 sys_clk,    // System clock, 25 MHz
  input  wire logic                 rst,        // Synchronous reset
  input  wire logic                 hsel,       // Slave select
  input  wire logic [31:0]          haddr,      // Address
  input  wire logic [1:0]           htrans,     // Transfer type
  input  wire logic                 hwrite,     // Write strobe
  input  wire logic [2:0]           hsize,      // Transfer size
  input  wire logic [31:0]          hwdata,     // Write data
  input  wire logic                 hready,     // Bus ready
  output logic                      hreadyout,  // Slave ready
  output logic                      hresp,      // Response
  output logic [31:0]               hrdata,     // Read data
  input  wire logic [NUM_PORTS-1:0] rts_req,    // UART request to send
  input  wire logic [NUM_PORTS-1:0] tx_busy,    // UART transmitter active
  input  wire logic [NUM_PORTS-1:0] uart_txd,   // UART serial out
  output logic [NUM_PORTS-1:0]      uart_rxd,   // Serial in to UART
  output logic [NUM_PORTS-1:0]      line_tx_o,  // Line driver data
  output logic [NUM_PORTS-1:0]      line_tx_oe, // Line driver enable
  input  wire logic [NUM_PORTS-1:0] line_rx_i,  // Line receiver data
  output logic [NUM_PORTS-1:0]      rx_enable   // Receiver enable
);

  port_cfg_type  first_port_mode_header_r;
  port_cfg_type  second_port_mode_header_r;
  port_stat_type stat [NUM_PORTS];
  port_cfg_type  cfg  [NUM_PORTS];
  logic          wr_pend_r;
  logic [7:0]    wr_ofs_r;
  logic [31:0]   rdata_r;
  logic          addr_ok;
  logic          take;
  logic          word_ok;
  logic          wr_port0;
  logic          wr_port1;
  logic [31:0]   rdata_nxt;
  logic [7:0]    stat_word;

  // Address phase accepted on any selected NONSEQ with ready high
  assign take     = hsel && hready && htrans == HTRANS_NONSEQ;
  assign word_ok  = hsize == HSIZE_WORD;
  assign addr_ok  = haddr[31:8] == 24'h00_0000;
  assign wr_port0 = wr_pend_r && wr_ofs_r == OFS_PORT0_MODE;
  assign wr_port1 = wr_pend_r && wr_ofs_r == OFS_PORT1_MODE;
  assign stat_word = {stat[1], stat[0]};

  assign rdata_nxt =
    !addr_ok                          ? 32'h0000_0000 :
    haddr[7:0] == OFS_PORT0_MODE      ? {29'h0000_0000, first_port_mode_header_r} :
    haddr[7:0] == OFS_PORT1_MODE      ? {29'h0000_0000, second_port_mode_header_r} :
    haddr[7:0] == OFS_STATUS          ? {24'h00_0000, stat_word} :
                                        32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= take && hwrite && word_ok && addr_ok;
      wr_ofs_r  <= take ? haddr[7:0] : wr_ofs_r;
      rdata_r   <= (take && !hwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      first_port_mode_header_r  <= CFG_RESET;
      second_port_mode_header_r <= CFG_RESET;
    end
    else
    begin
      if (wr_port0)
        first_port_mode_header_r <= hwdata[CFG_W-1:0];
      if (wr_port1)
        second_port_mode_header_r <= hwdata[CFG_W-1:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  assign cfg[0] = first_port_mode_header_r;
  assign cfg[1] = second_port_mode_header_r;

  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
      port_dir_ctrl u_port
      (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .cfg        (cfg[p]),
        .rts_req    (rts_req[p]),
        .tx_busy    (tx_busy[p]),
        .uart_txd   (uart_txd[p]),
        .line_rx_i  (line_rx_i[p]),
        .line_tx_o  (line_tx_o[p]),
        .line_tx_oe (line_tx_oe[p]),
        .rx_enable  (rx_enable[p]),
        .uart_rxd   (uart_rxd[p]),
        .stat       (stat[p])
      );
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wr_addr(logic [7:0] ofs);
    take && hwrite && word_ok && addr_ok && haddr[7:0] == ofs;
  endsequence

  a_port0_write: assert property (
    s_wr_addr(OFS_PORT0_MODE) ##1 1'b1 |=>
      first_port_mode_header_r == $past(hwdata[CFG_W-1:0]) &&
      $stable(second_port_mode_header_r))
    else $error("port0 write wrong or leaked");
  a_port1_write: assert property (
    s_wr_addr(OFS_PORT1_MODE) ##1 1'b1 |=>
      second_port_mode_header_r == $past(hwdata[CFG_W-1:0]) &&
      $stable(first_port_mode_header_r))
    else $error("port1 write wrong or leaked");
  a_status_read: assert property (
    take && !hwrite && addr_ok && haddr[7:0] == OFS_STATUS |=>
      hrdata[7:0] == $past(stat_word))
    else $error("status read mismatch");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or error");

endmodule

//--- test/line_peer.sv
// Purpose: Other transceivers sharing each port's line
// Assumes: Line biasing pulls an undriven pair to 1
// Notes:   Peer drives only while the device has released the line
`timescale 1ns/1ns
module line_peer
(
  input  wire logic [1:0] dut_oe, // Device driver enable
  input  wire logic [1:0] dut_tx, // Device driver data
  input  wire logic [1:0] want,   // Peer wants the line
  input  wire logic [1:0] data,   // Peer data
  output logic [1:0]      line    // Resolved line level
);
  logic [1:0] peer_oe;
  assign peer_oe = want & ~dut_oe;
  assign line = (dut_oe & dut_tx) | (peer_oe & data) | (~dut_oe & ~peer_oe);
endmodule

//--- test/rs485_driver_enable_control_tb.sv
// Purpose: Self-checking bench for the two-port direction controller
// Assumes: Zero-wait bus slave, link outputs one cycle behind inputs
// Notes:   Random modes and modem inputs plus echo, peer and frame cases
`timescale 1ns/1ns
module rs485_driver_enable_control_tb
  import rs485_dir_pkg::*;
;
  logic        sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, hr_q, rd, st;
  logic [1:0]  htrans = 0, rts_req = 0, tx_busy = 0, uart_txd = 3, uart_rxd, line_tx_o;
  logic [1:0]  line_tx_oe, line_rx_i, rx_enable, want = 0, pdat = 3, e;
  logic [1:0]  prv_rts, prv_busy, prv_txd;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [2:0]  cfg [2];
  logic [9:0]  bits;
  int          fail_count = 0, n_checks = 0;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) hr_q <= hrdata;

  rs485_dir_ctrl dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rts_req, .tx_busy, .uart_txd,
    .uart_rxd, .line_tx_o, .line_tx_oe, .line_rx_i, .rx_enable);
  line_peer peer (.dut_oe(line_tx_oe), .dut_tx(line_tx_o), .want, .data(pdat),
    .line(line_rx_i));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    #1 rd = hr_q;
    chk("hresp", 0, hresp);
  endtask

  // Expected {rx_enable, driver enable} for a mode and modem inputs
  function automatic logic [1:0] expect_dir(input logic [2:0] c, input logic r, input logic b);
    logic g;
    g = c[1] ? b : (c[0] ? r : 1'b1);
    return {~(c[2] & (|c[1:0]) & g), g};
  endfunction

  task automatic step(input logic [1:0] r, input logic [1:0] b, input logic [1:0] t);
    @(posedge sys_clk);
    prv_rts = rts_req;
    prv_busy = tx_busy;
    prv_txd = uart_txd;
    rts_req <= r;
    tx_busy <= b;
    uart_txd <= t;
    @(negedge sys_clk);
    for (int p = 0; p < 2; p++)
    begin
      e = expect_dir(cfg[p], prv_rts[p], prv_busy[p]);
      chk("line_tx_oe", e[0], line_tx_oe[p]);
      chk("rx_enable", e[1], rx_enable[p]);
      chk("line_tx_o", prv_txd[p], line_tx_o[p]);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #(40 * 10000);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'h28f6_33cc));
    cfg[0] = 3'h0;
    cfg[1] = 3'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    step(0, 0, 3);
    ahb(1, 8'h0C, 32'hFFFF_FFFF);
    ahb(1, OFS_STATUS, 32'hFFFF_FFFF);
    for (int a = 0; a < 16; a += 4)
      if (a != 8)
      begin
        ahb(0, 8'(a), 0);
        chk("reg_reset", 0, rd);
      end
    for (int i = 0; i < 16; i++)
    begin
      cfg[0] = 3'(i);
      cfg[1] = 3'($urandom);
      ahb(1, OFS_PORT0_MODE, {29'h0, cfg[0]});
      ahb(1, OFS_PORT1_MODE, {29'h0, cfg[1]});
      @(posedge sys_clk);
      repeat (20) step(2'($urandom), 2'($urandom), 2'($urandom));
      ahb(0, OFS_PORT1_MODE, 0);
      chk("port1_mode", {29'h0, cfg[1]}, rd);
      ahb(0, OFS_STATUS, 0);
      st = 0;
      for (int p = 0; p < 2; p++)
      begin
        e = expect_dir(cfg[p], rts_req[p], tx_busy[p]);
        st[p*4 +: 4] = {e, tx_busy[p], rts_req[p]};
      end
      chk("status", st, rd);
    end
    // Own characters heard with echo, muted without
    for (int ne = 0; ne < 2; ne++)
    begin
      cfg[0] = ne ? 3'h6 : 3'h2;
      ahb(1, OFS_PORT0_MODE, {29'h0, cfg[0]});
      @(posedge sys_clk);
      repeat (8) step(2'b00, 2'b01, 2'b10);
      chk("uart_rxd", 32'(ne), uart_rxd[0]);
    end
    want <= 2'b01;
    pdat <= 2'b00;
    repeat (8) step(0, 0, 3);
    chk("peer_rxd", 0, uart_rxd[0]);
    repeat (8) step(0, 1, 3);
    chk("own_rxd", 1, uart_rxd[0]);
    want <= 2'b00;
    // One full character at the fastest line rate
    cfg[1] = 3'h2;
    ahb(1, OFS_PORT1_MODE, 32'h0000_0002);
    @(posedge sys_clk);
    bits = {1'b1, 8'($urandom), 1'b0};
    for (int k = 0; k < 10; k++)
      repeat (BIT_CYCLES) step(0, 2'b10, {bits[k], 1'b1});
    repeat (3) step(0, 0, 3);
    print_verdict();
  end
endmodule
